// ===== hw/sal_pkg.sv
// Purpose: Constants for the layer-1 activation control block
// Assumes: 25 MHz core clock, 4-bit control channel 0 codes
// Notes: Codes, info selectors and reset values live here only
package sal_pkg;
    // ----------------------------------------------------------
    // Indication codes
    // ----------------------------------------------------------
    localparam logic [3:0] IND_DEACT_REQ = 4'h0;
    localparam logic [3:0] IND_RESET = 4'h1;
    localparam logic [3:0] IND_TEST = 4'h2;
    localparam logic [3:0] IND_RESYNC = 4'h4;
    localparam logic [3:0] IND_POWER_UP = 4'h7;
    localparam logic [3:0] IND_ACT_REQ = 4'h8;
    localparam logic [3:0] IND_LOOP_REQ = 4'ha;
    localparam logic [3:0] IND_FAR_VIOL = 4'hb;
    localparam logic [3:0] IND_ACT_LOW = 4'hc;
    localparam logic [3:0] IND_ACT_HIGH = 4'hd;
    localparam logic [3:0] IND_LOOP_ACT = 4'he;
    localparam logic [3:0] IND_DEACT_CONF = 4'hf;
    // ----------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------
    localparam logic [3:0] CMD_TIMING = 4'h0;
    localparam logic [3:0] CMD_RESET = 4'h1;
    localparam logic [3:0] CMD_TEST1 = 4'h2;
    localparam logic [3:0] CMD_TEST2 = 4'h3;
    localparam logic [3:0] CMD_ACT_LOW = 4'h8;
    localparam logic [3:0] CMD_ACT_HIGH = 4'h9;
    localparam logic [3:0] CMD_LOOP = 4'ha;
    localparam logic [3:0] CMD_DEACT_IND = 4'hf;
    // ----------------------------------------------------------
    // Received info codes (line receiver status)
    // ----------------------------------------------------------
    localparam logic [1:0] RX_INFO0 = 2'h0;
    localparam logic [1:0] RX_INFO2 = 2'h1;
    localparam logic [1:0] RX_INFO4 = 2'h2;
    localparam logic [1:0] RX_INFOX = 2'h3;
    // ----------------------------------------------------------
    // Transmitted info selectors
    // ----------------------------------------------------------
    localparam logic [2:0] TX_INFO0 = 3'h0;
    localparam logic [2:0] TX_INFO1 = 3'h1;
    localparam logic [2:0] TX_INFO3 = 3'h3;
    localparam logic [2:0] TX_TEST1 = 3'h4;
    localparam logic [2:0] TX_TEST2 = 3'h5;
    // ----------------------------------------------------------
    // Line pattern and frame geometry
    // ----------------------------------------------------------
    localparam logic [7:0] INFO1_PATTERN = 8'h3f;
    localparam int FRAME_BITS = 48;
    localparam logic [5:0] FRAME_LAST = 6'h2f;
    // Reset values of enables
    localparam logic RST_TRX_DISABLE = 1'b0;
    localparam logic RST_TX_DISABLE = 1'b1;
endpackage : sal_pkg

// ===== hw/sal_layer1_ctrl.sv
// Purpose: Layer-1 activation, deactivation and line pattern control
// Assumes: line bit strobe one cycle per line bit, receiver decodes infos
// Notes: Indications held on ind_code until the state changes, or until an input of the active or loop states changes
`timescale 1ns/10ps
// Operation
// - Deactivation from activated/lost framing gives 0000
// - Signal without sync gives code 0100
// - Bus clocks supplied gives power-up 0111
// - Loop closed 1010, loop activated 1110
// - Violation code 1011 only when enabled
// - Info 4: 1100 low or 1101 high priority
// - Deactivation confirm 1111, clocks stop if enabled
// - Info 1 sends 00111111 repeatedly, AMI coded
// - Test 1 one pulse/frame, test 2 continuous
// - Software control freezes state machine unless transceiver disabled
// - Status changes raise interrupt, read clears it
// - Clock stop bit low keeps clocks running
// - Clock stop: pins idle, level detector only
// - Level detect wakes clocks or raises interrupt
// - Reset: transceiver enabled, transmitter disabled
// - Transceiver disable stops layer 1, clock pins input
// - Internal loop routes transmit to receive, B/D back
// - Internal loop keeps awake detector, reports resync
// - External loop needs bit, awake detector disabled
module sal_layer1_ctrl
    import sal_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [3:0] ctrl_channel0_code,
    input wire logic cmd_valid,
    input wire logic [1:0] rx_info,
    input wire logic rx_sync,
    input wire logic rx_level,
    input wire logic rx_code_violation,
    input wire logic rx_prio_high,
    input wire logic line_bit_stb,
    input wire logic far_violation_enable,
    input wire logic layer1_software_control,
    input wire logic clock_stop_in_powerdown,
    input wire logic level_detect_disable,
    input wire logic software_power_up,
    input wire logic transceiver_disable_wr,
    input wire logic transceiver_disable_in,
    input wire logic transmit_disable_wr,
    input wire logic transmit_disable_in,
    input wire logic external_loop_bit,
    input wire logic analog_loop_bit,
    input wire logic [2:0] transmit_command_reg,
    input wire logic receiver_status_rd,
    input wire logic receiver_change_mask,
    input wire logic [1:0] up_bd_data,
    output logic [3:0] ind_code,
    output logic [2:0] tx_info_sel,
    output logic tx_mark,
    output logic tx_polarity,
    output logic tx_enable,
    output logic loop_internal,
    output logic awake_det_en,
    output logic [1:0] down_bd_data,
    output logic clocks_running,
    output logic downstream_data_line,
    output logic upstream_data_line,
    output logic data_clock_pin_oe,
    output logic frame_sync_pin_oe,
    output logic bit_clock_pin,
    output logic [3:0] receiver_status_reg,
    output logic receiver_change_irq,
    output logic level_detect_irq,
    output logic transceiver_disable,
    output logic transmit_disable
);
    // ----------------------------------------------------------
    // State machine
    // ----------------------------------------------------------
    typedef enum logic [3:0] {
        S_RESET = 4'h0, S_PEND_DEACT = 4'h1, S_PDOWN = 4'h2,
        S_PUP = 4'h3, S_PEND_ACT = 4'h4, S_UNSYNC = 4'h5,
        S_SYNC = 4'h6, S_ACTIVE = 4'h7, S_LOST = 4'h8,
        S_LOOP_CL = 4'h9, S_LOOP_ACT = 4'ha, S_TEST1 = 4'hb,
        S_TEST2 = 4'hc
    } sal_state_e;

    sal_state_e state_q, state_d;
    logic prio_high_q;
    logic viol_flag_q;
    logic [7:0] pat_q;
    logic [5:0] bit_cnt_q;
    logic polarity_q;
    logic [3:0] status_prev_q;
    logic clk_stopped_q;
    logic mark_d;
    logic line_ok;
    logic ld_event;

    // Layer 1 usable only when transceiver enabled
    assign line_ok = !transceiver_disable;
    // Line level in power-down while detector armed
    assign ld_event = line_ok && rx_level && awake_det_en
        && (state_q == S_PDOWN);

    // Next state of the internal activation machine
    always_comb
    begin
        state_d = state_q;
        if (cmd_valid && ctrl_channel0_code == CMD_RESET)
            state_d = S_RESET;
        else if (cmd_valid && ctrl_channel0_code == CMD_TEST1)
            state_d = S_TEST1;
        else if (cmd_valid && ctrl_channel0_code == CMD_TEST2)
            state_d = S_TEST2;
        else if (cmd_valid && ctrl_channel0_code == CMD_LOOP)
            state_d = S_LOOP_CL;
        else
        begin
            unique case (state_q)
                S_RESET, S_TEST1, S_TEST2:
                    if (cmd_valid && ctrl_channel0_code == CMD_DEACT_IND)
                        state_d = S_PDOWN;
                S_PEND_DEACT:
                    if (cmd_valid && ctrl_channel0_code == CMD_DEACT_IND)
                        state_d = S_PDOWN;
                S_PDOWN:
                    if (rx_info != RX_INFO0 && rx_level)
                        state_d = S_UNSYNC;
                    else if (cmd_valid
                        && ctrl_channel0_code == CMD_TIMING)
                        state_d = S_PUP;
                S_PUP:
                    if (cmd_valid && (ctrl_channel0_code == CMD_ACT_LOW
                        || ctrl_channel0_code == CMD_ACT_HIGH))
                        state_d = S_PEND_ACT;
                    else if (cmd_valid
                        && ctrl_channel0_code == CMD_DEACT_IND)
                        state_d = S_PDOWN;
                    else if (rx_info != RX_INFO0)
                        state_d = S_UNSYNC;
                S_PEND_ACT, S_UNSYNC:
                    if (rx_sync && rx_info == RX_INFO4)
                        state_d = S_ACTIVE;
                    else if (rx_sync && rx_info == RX_INFO2)
                        state_d = S_SYNC;
                    else if (state_q == S_PEND_ACT
                        && rx_info == RX_INFOX)
                        state_d = S_UNSYNC;
                S_SYNC, S_ACTIVE:
                    if (rx_info == RX_INFO0)
                        state_d = S_PEND_DEACT;
                    else if (!rx_sync)
                        state_d = S_LOST;
                    else if (rx_info == RX_INFO4)
                        state_d = S_ACTIVE;
                    else if (rx_info == RX_INFO2)
                        state_d = S_SYNC;
                S_LOST:
                    if (rx_info == RX_INFO0)
                        state_d = S_PEND_DEACT;
                    else if (rx_sync && rx_info == RX_INFO4)
                        state_d = S_ACTIVE;
                    else if (rx_sync && rx_info == RX_INFO2)
                        state_d = S_SYNC;
                S_LOOP_CL:
                    if (rx_sync)
                        state_d = S_LOOP_ACT;
                    else if (cmd_valid
                        && ctrl_channel0_code == CMD_DEACT_IND)
                        state_d = S_PDOWN;
                S_LOOP_ACT:
                    if (cmd_valid && ctrl_channel0_code == CMD_DEACT_IND)
                        state_d = S_PDOWN;
                default:
                    state_d = S_RESET;
            endcase
        end
        if (!line_ok)
            state_d = S_RESET;
    end

    // State register, frozen under software control
    always_ff @(posedge core_clk)
    begin
        if (srst)
            state_q <= S_RESET;
        else if (clk_en && (!layer1_software_control || !line_ok))
            state_q <= state_d;
    end

    // Priority class latched on activation request
    always_ff @(posedge core_clk)
    begin
        if (srst)
            prio_high_q <= 1'b0;
        else if (clk_en && cmd_valid)
        begin
            if (ctrl_channel0_code == CMD_ACT_LOW)
                prio_high_q <= 1'b0;
            else if (ctrl_channel0_code == CMD_ACT_HIGH)
                prio_high_q <= 1'b1;
        end
    end

    // Far-end violation flag, only when enabled
    always_ff @(posedge core_clk)
    begin
        if (srst)
            viol_flag_q <= 1'b0;
        else if (clk_en)
            viol_flag_q <= far_violation_enable && rx_code_violation
                && (state_q == S_ACTIVE);
    end

    // ----------------------------------------------------------
    // Indication encoding, held while state and its active/loop inputs hold
    // ----------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
            ind_code <= IND_RESET;
        else if (clk_en)
        begin
            unique case (state_q)
                S_RESET: ind_code <= IND_RESET;
                S_TEST1, S_TEST2: ind_code <= IND_TEST;
                S_PEND_DEACT: ind_code <= IND_DEACT_REQ;
                S_PDOWN: ind_code <= IND_DEACT_CONF;
                S_PUP: ind_code <= IND_POWER_UP;
                S_PEND_ACT, S_UNSYNC, S_LOST:
                    ind_code <= IND_RESYNC;
                S_SYNC: ind_code <= IND_ACT_REQ;
                S_ACTIVE:
                    if (viol_flag_q)
                        ind_code <= IND_FAR_VIOL;
                    else if (rx_prio_high || prio_high_q)
                        ind_code <= IND_ACT_HIGH;
                    else
                        ind_code <= IND_ACT_LOW;
                S_LOOP_CL, S_LOOP_ACT:
                    if (rx_level && !external_loop_bit)
                        ind_code <= IND_RESYNC;
                    else if (state_q == S_LOOP_ACT)
                        ind_code <= IND_LOOP_ACT;
                    else
                        ind_code <= IND_LOOP_REQ;
                default: ind_code <= IND_RESET;
            endcase
        end
    end

    // ----------------------------------------------------------
    // Transmit info selection
    // ----------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
            tx_info_sel <= TX_INFO0;
        else if (clk_en)
        begin
            if (!line_ok)
                tx_info_sel <= TX_INFO0;
            else if (layer1_software_control)
                tx_info_sel <= transmit_command_reg;
            else
            begin
                unique case (state_q)
                    S_PEND_ACT: tx_info_sel <= TX_INFO1;
                    S_SYNC, S_ACTIVE, S_LOOP_CL, S_LOOP_ACT:
                        tx_info_sel <= TX_INFO3;
                    S_TEST1: tx_info_sel <= TX_TEST1;
                    S_TEST2: tx_info_sel <= TX_TEST2;
                    default: tx_info_sel <= TX_INFO0;
                endcase
            end
        end
    end

    // Bit counter and info 1 pattern rotation
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            bit_cnt_q <= '0;
            pat_q <= INFO1_PATTERN;
        end
        else if (clk_en && line_bit_stb)
        begin
            bit_cnt_q <= (bit_cnt_q == FRAME_LAST) ? '0
                : bit_cnt_q + 6'h1;
            pat_q <= {pat_q[6:0], pat_q[7]};
        end
    end

    // Mark selection per info
    always_comb
    begin
        unique case (tx_info_sel)
            TX_INFO1: mark_d = pat_q[7];
            TX_TEST1: mark_d = (bit_cnt_q == '0);
            TX_TEST2: mark_d = 1'b1;
            TX_INFO3: mark_d = up_bd_data[0];
            default: mark_d = 1'b0;
        endcase
    end

    // AMI coding: each mark flips polarity
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            tx_mark <= 1'b0;
            polarity_q <= 1'b0;
        end
        else if (clk_en && line_bit_stb)
        begin
            tx_mark <= mark_d;
            if (mark_d)
                polarity_q <= !polarity_q;
        end
    end
    assign tx_polarity = polarity_q;
    assign tx_enable = line_ok && !transmit_disable;

    // ----------------------------------------------------------
    // Loops
    // ----------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            loop_internal <= 1'b0;
            awake_det_en <= 1'b1;
            down_bd_data <= '0;
        end
        else if (clk_en)
        begin
            loop_internal <= line_ok && ((state_q == S_LOOP_CL)
                || (state_q == S_LOOP_ACT)
                || (layer1_software_control && analog_loop_bit));
            awake_det_en <= line_ok && !(external_loop_bit
                && loop_internal);
            down_bd_data <= loop_internal ? up_bd_data : '0;
        end
    end

    // ----------------------------------------------------------
    // Power-down clock handling
    // ----------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
            clk_stopped_q <= 1'b0;
        else if (clk_en)
        begin
            if (!clock_stop_in_powerdown || software_power_up)
                clk_stopped_q <= 1'b0;
            else if (ld_event && !level_detect_disable)
                clk_stopped_q <= 1'b0;
            else if (state_q == S_PDOWN && state_d == S_PDOWN)
                clk_stopped_q <= 1'b1;
            else if (state_q != S_PDOWN)
                clk_stopped_q <= 1'b0;
        end
    end
    assign clocks_running = !clk_stopped_q;
    assign downstream_data_line = 1'b1; // Idle high
    assign upstream_data_line = 1'b1;
    assign bit_clock_pin = 1'b1; // High when stopped
    assign data_clock_pin_oe = line_ok && !clk_stopped_q;
    assign frame_sync_pin_oe = line_ok;

    // Level-detect interrupt, set wins over clear
    always_ff @(posedge core_clk)
    begin
        if (srst)
            level_detect_irq <= 1'b0;
        else if (clk_en)
        begin
            if (ld_event && level_detect_disable)
                level_detect_irq <= 1'b1;
            else if (receiver_status_rd)
                level_detect_irq <= 1'b0;
        end
    end

    // Receiver status and change interrupt
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            receiver_status_reg <= '0;
            status_prev_q <= '0;
            receiver_change_irq <= 1'b0;
        end
        else if (clk_en)
        begin
            receiver_status_reg <= {rx_level, rx_sync, rx_info};
            status_prev_q <= receiver_status_reg;
            if (receiver_status_reg != status_prev_q
                && !receiver_change_mask)
                receiver_change_irq <= 1'b1;
            else if (receiver_status_rd)
                receiver_change_irq <= 1'b0;
        end
    end

    // Enable bits with documented reset values
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            transceiver_disable <= RST_TRX_DISABLE;
            transmit_disable <= RST_TX_DISABLE;
        end
        else if (clk_en)
        begin
            if (transceiver_disable_wr)
                transceiver_disable <= transceiver_disable_in;
            if (transmit_disable_wr)
                transmit_disable <= transmit_disable_in;
        end
    end

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    property p_deact_req;
        @(posedge core_clk) disable iff (srst)
        clk_en && state_q == S_PEND_DEACT |=> ind_code == IND_DEACT_REQ;
    endproperty
    a_deact_req: assert property (p_deact_req)
        else $error("deactivation request code wrong");
    property p_power_up;
        @(posedge core_clk) disable iff (srst)
        clk_en && state_q == S_PUP |=> ind_code == IND_POWER_UP;
    endproperty
    a_power_up: assert property (p_power_up)
        else $error("power-up code wrong");
    property p_viol_gate;
        @(posedge core_clk) disable iff (srst)
        ind_code == IND_FAR_VIOL |-> $past(far_violation_enable, 2);
    endproperty
    a_viol_gate: assert property (p_viol_gate)
        else $error("violation reported while disabled");
    property p_sw_freeze;
        @(posedge core_clk) disable iff (srst)
        layer1_software_control && line_ok |=> $stable(state_q);
    endproperty
    a_sw_freeze: assert property (p_sw_freeze)
        else $error("state moved under software control");
    property p_irq_change;
        @(posedge core_clk) disable iff (srst)
        clk_en && !receiver_change_mask
            && receiver_status_reg != status_prev_q
            |=> receiver_change_irq;
    endproperty
    a_irq_change: assert property (p_irq_change)
        else $error("status change missed");
    property p_clk_run;
        @(posedge core_clk) disable iff (srst)
        clk_en && !clock_stop_in_powerdown |=> clocks_running;
    endproperty
    a_clk_run: assert property (p_clk_run)
        else $error("clocks stopped with stop bit clear");
    property p_trx_dis;
        @(posedge core_clk) disable iff (srst)
        transceiver_disable |-> !data_clock_pin_oe && !frame_sync_pin_oe;
    endproperty
    a_trx_dis: assert property (p_trx_dis)
        else $error("clock pins driven while disabled");
    property p_loop_route;
        @(posedge core_clk) disable iff (srst)
        clk_en && loop_internal |=> down_bd_data == $past(up_bd_data);
    endproperty
    a_loop_route: assert property (p_loop_route)
        else $error("loop data not returned");
endmodule : sal_layer1_ctrl

// ===== bench/sal_nt_model.sv
// Purpose: Network termination model facing the layer-1 block
// Assumes: Answers info 1 with info 2 and info 3 with info 4
// Notes: DELAY sets how slowly the far end answers
`timescale 1ns/10ps
module sal_nt_model
    import sal_pkg::*;
#(
    parameter int DELAY = 6
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [2:0] tx_info_sel,
    input wire logic answer,
    input wire logic lose,
    input wire logic loop_internal,
    output logic [1:0] rx_info,
    output logic rx_sync,
    output logic rx_level,
    output logic line_bit_stb
);
    logic [3:0] wait_q;
    logic [1:0] div_q;
    // ----------------------------------------------------------
    // Line bit strobe and received info
    // ----------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        div_q <= srst ? 2'h0 : div_q + 2'h1;
        if (srst || !answer || lose)
        begin
            rx_info <= lose ? RX_INFOX : RX_INFO0;
            wait_q <= 4'h0;
        end
        else if (wait_q != 4'(DELAY))
            wait_q <= wait_q + 4'h1;
        else
            rx_info <= (tx_info_sel == TX_INFO3) ? RX_INFO4 : RX_INFO2;
    end
    // Sync on a valid info or on the device's own looped signal
    assign rx_sync = loop_internal || (rx_info == RX_INFO2)
        || (rx_info == RX_INFO4);
    assign rx_level = rx_info != RX_INFO0;
    assign line_bit_stb = div_q == 2'h3;
endmodule : sal_nt_model

// ===== bench/sal_layer1_ctrl_tb_top.sv
// Purpose: Self-checking bench for the layer-1 activation control
// Assumes: 25 MHz core clock, network model on the line side
// Notes: Each scenario is one task that judges its own results
`timescale 1ns/10ps
module sal_layer1_ctrl_tb_top
    import sal_pkg::*;
;
    logic core_clk, srst, clk_en, cmd_valid, rx_sync, rx_level, line_bit_stb;
    logic [3:0] ctrl_channel0_code, ind_code, receiver_status_reg;
    logic [1:0] rx_info, up_bd_data, down_bd_data;
    logic [2:0] transmit_command_reg, tx_info_sel;
    logic rx_code_violation, rx_prio_high, far_violation_enable;
    logic layer1_software_control, clock_stop_in_powerdown;
    logic level_detect_disable, software_power_up, transceiver_disable_wr;
    logic transceiver_disable_in, transmit_disable_wr, transmit_disable_in;
    logic external_loop_bit, analog_loop_bit, receiver_status_rd;
    logic receiver_change_mask, tx_mark, tx_polarity, tx_enable;
    logic loop_internal, awake_det_en, clocks_running, bit_clock_pin;
    logic downstream_data_line, upstream_data_line, data_clock_pin_oe;
    logic frame_sync_pin_oe, receiver_change_irq, level_detect_irq;
    logic transceiver_disable, transmit_disable, answer, lose;
    int miscompares, num_checks;
    sal_layer1_ctrl u_sal_layer1_ctrl (.*);
    sal_nt_model u_sal_nt_model (.*);
    // ----------------------------------------------------------
    // Clock, helpers and closing
    // ----------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input logic [3:0] c);
        ctrl_channel0_code = c;
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
    endtask : cmd
    // Wait a bounded time for an indication, then judge it
    task automatic wait_ind(input logic [3:0] exp);
        for (int i = 0; i < 200 && ind_code !== exp; i++) tick(1);
        chk(ind_code, exp);
    endtask : wait_ind
    task automatic conclude();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_activate();
        chk({2'h0, tx_enable, transmit_disable}, 4'h1);
        chk({3'h0, transceiver_disable}, 4'h0);
        cmd(CMD_DEACT_IND);
        wait_ind(IND_DEACT_CONF);
        chk({3'h0, clocks_running}, 4'h1);
        cmd(CMD_TIMING);
        wait_ind(IND_POWER_UP);
        cmd(CMD_ACT_LOW);
        tick(3);
        chk({1'b0, tx_info_sel}, {1'b0, TX_INFO1});
        answer = 1'b1;
        wait_ind(IND_ACT_LOW);
        chk({3'h0, receiver_change_irq}, 4'h1);
        receiver_status_rd = 1'b1;
        tick(1);
        receiver_status_rd = 1'b0;
        tick(1);
        chk({3'h0, receiver_change_irq}, 4'h0);
        rx_prio_high = 1'b1;
        wait_ind(IND_ACT_HIGH);
        rx_prio_high = 1'b0;
        far_violation_enable = 1'b1;
        rx_code_violation = 1'b1;
        wait_ind(IND_FAR_VIOL);
        rx_code_violation = 1'b0;
        answer = 1'b0;
        wait_ind(IND_DEACT_REQ);
        clock_stop_in_powerdown = 1'b1;
        cmd(CMD_DEACT_IND);
        wait_ind(IND_DEACT_CONF);
        tick(2);
        chk({clocks_running, bit_clock_pin, downstream_data_line}, 4'h3);
        software_power_up = 1'b1;
        tick(2);
        chk({3'h0, clocks_running}, 4'h1);
        {software_power_up, level_detect_disable, answer} = 3'h3;
        wait_ind(IND_RESYNC);
        chk({3'h0, level_detect_irq}, 4'h1);
        {clock_stop_in_powerdown, level_detect_disable, answer} = 3'h0;
        $display("activation test done");
    endtask : t_activate
    task automatic t_loop();
        cmd(CMD_RESET);
        wait_ind(IND_RESET);
        up_bd_data = 2'h2;
        cmd(CMD_LOOP);
        wait_ind(IND_LOOP_REQ);
        tick(1);
        chk({loop_internal, down_bd_data, awake_det_en}, 4'hd);
        answer = 1'b1;
        wait_ind(IND_LOOP_ACT);
        lose = 1'b1;
        wait_ind(IND_RESYNC);
        chk({3'h0, loop_internal}, 4'h1);
        external_loop_bit = 1'b1;
        tick(2);
        chk({3'h0, awake_det_en}, 4'h0);
        {lose, answer, external_loop_bit} = 3'h0;
        $display("loop test done");
    endtask : t_loop
    task automatic t_modes();
        cmd(CMD_TEST1);
        wait_ind(IND_TEST);
        chk({1'b0, tx_info_sel}, {1'b0, TX_TEST1});
        cmd(CMD_TEST2);
        tick(6);
        chk({1'b0, tx_info_sel}, {1'b0, TX_TEST2});
        chk({3'h0, tx_mark}, 4'h1);
        cmd(CMD_RESET);
        wait_ind(IND_RESET);
        layer1_software_control = 1'b1;
        cmd(CMD_TIMING);
        transmit_command_reg = TX_INFO1;
        tick(3);
        chk({1'b0, tx_info_sel}, {1'b0, TX_INFO1});
        cmd(CMD_TEST1);
        tick(3);
        chk(ind_code, IND_RESET);
        transmit_command_reg = TX_INFO0;
        answer = 1'b1;
        tick(12);
        transmit_command_reg = TX_INFO3;
        tick(4);
        chk(receiver_status_reg, {2'h3, RX_INFO4});
        answer = 1'b0;
        layer1_software_control = 1'b0;
        {transceiver_disable_in, transceiver_disable_wr} = 2'h3;
        tick(1);
        transceiver_disable_wr = 1'b0;
        tick(2);
        chk({transceiver_disable, data_clock_pin_oe, frame_sync_pin_oe}, 4'h4);
        $display("mode test done");
    endtask : t_modes
    // ----------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------
    initial
    begin
        {srst, clk_en} = 2'h3;
        {cmd_valid, ctrl_channel0_code, rx_code_violation, rx_prio_high} = 7'h0;
        {far_violation_enable, layer1_software_control} = 2'h0;
        {clock_stop_in_powerdown, level_detect_disable, software_power_up} = 3'h0;
        {transceiver_disable_wr, transceiver_disable_in} = 2'h0;
        {transmit_disable_wr, transmit_disable_in, external_loop_bit} = 3'h0;
        {analog_loop_bit, transmit_command_reg, receiver_status_rd} = 5'h0;
        {receiver_change_mask, up_bd_data, answer, lose} = 5'h0;
        tick(20);
        srst = 1'b0;
        t_activate();
        t_loop();
        t_modes();
        conclude();
    end
    initial
    begin
        #2000000;
        miscompares++;
        conclude();
    end
endmodule : sal_layer1_ctrl_tb_top
